//--- logic/fifo_flags.v
// Dual-clock FIFO with standard and fall-through timing, status flags
// and programmable almost-empty/almost-full offsets.
// Assumes write and read clocks arrive as slow pins sampled by pclk,
// and software reaches offset and status registers over APB.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "fifo_flags_consts.vh"

module fifo_flags (
  input  wire                pclk,
  input  wire                presetn,
  input  wire [7:0]          paddr,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire                wclk_pin,
  input  wire                wen_n,
  input  wire [`DATA_W-1:0]  din,
  input  wire                rclk_pin,
  input  wire                ren_n,
  input  wire                timing_mode_serial_in,
  input  wire                load_select,
  input  wire                default_offset_pick_hi,
  input  wire                default_offset_pick_lo,
  output reg  [`DATA_W-1:0]  dout,
  output reg                 empty_flag_n,
  output reg                 full_flag_n,
  output reg                 output_ready_n,
  output reg                 input_ready_n,
  output reg                 almost_empty_flag_n,
  output reg                 almost_full_flag_n,
  output reg                 half_full_flag_n
);

  // Pin synchronisers. Every control pin takes the same two-flop path and
  // stage 1 feeds only stage 2; the clock pins get a third flop so that
  // their rising edges can be found.
  // Bits: 0 write clock, 1 read clock, 2 write enable, 3 read enable,
  // 4 mode, 5 load select, 6 offset pick hi, 7 offset pick lo
  localparam       NPIN     = 8;
  // Enables rest high so that reset release cannot look like a request
  localparam [7:0] PIN_IDLE = 8'h0C;

  wire [NPIN-1:0] pin_raw = {default_offset_pick_lo, default_offset_pick_hi,
                             load_select, timing_mode_serial_in,
                             ren_n, wen_n, rclk_pin, wclk_pin};
  wire [NPIN-1:0] pin_s;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      reg s1_q;
      reg s2_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= PIN_IDLE[gi];
          s2_q <= PIN_IDLE[gi];
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
        end
      end
      assign pin_s[gi] = s2_q;
    end
  endgenerate

  wire wclk_sy = pin_s[0];
  wire rclk_sy = pin_s[1];
  wire wen_sy  = pin_s[2];
  wire ren_sy  = pin_s[3];
  wire mode_sy = pin_s[4];
  wire ld_sy   = pin_s[5];
  wire hi_sy   = pin_s[6];
  wire lo_sy   = pin_s[7];

  // Data takes the same two flops as the write enable, so a word and its
  // enable reach the memory in the same pclk cycle
  reg [`DATA_W-1:0] din_s1;
  reg [`DATA_W-1:0] din_s2;
  reg               wclk_q3;
  reg               rclk_q3;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_s1  <= {`DATA_W{1'b0}};
      din_s2  <= {`DATA_W{1'b0}};
      wclk_q3 <= 1'b0;
      rclk_q3 <= 1'b0;
    end else begin
      din_s1  <= din;
      din_s2  <= din_s1;
      wclk_q3 <= wclk_sy;
      rclk_q3 <= rclk_sy;
    end
  end

  // A pin edge is seen two to three pclk after it happens; pin pulses
  // shorter than one pclk period may be missed
  wire wclk_rise = wclk_sy & ~wclk_q3;
  wire rclk_rise = rclk_sy & ~rclk_q3;

  // Strap capture after reset release, once the synchronisers are full
  reg [1:0]        strap_cnt_q;
  reg              mode_ok_q;
  reg              ft_q;
  reg              load_sel_q;
  reg [`CNT_W-1:0] def_ofs_q;
  reg [`CNT_W-1:0] def_ofs_d;
  wire             strap_take = ~mode_ok_q & (strap_cnt_q == `STRAP_AT);

  always @* begin
    case ({ld_sy, hi_sy, lo_sy})
      3'h2:    def_ofs_d = `OFS_L_HL;
      3'h1:    def_ofs_d = `OFS_L_LH;
      3'h3:    def_ofs_d = `OFS_L_HH;
      3'h6:    def_ofs_d = `OFS_H_HL;
      3'h4:    def_ofs_d = `OFS_H_LL;
      3'h5:    def_ofs_d = `OFS_H_LH;
      3'h7:    def_ofs_d = `OFS_H_HH;
      default: def_ofs_d = `OFS_L_LL;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
      mode_ok_q   <= 1'b0;
      ft_q        <= 1'b0;
      load_sel_q  <= 1'b0;
      def_ofs_q   <= `OFS_L_LL;
    end else if (!mode_ok_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_take) begin
        // Captured once; later pin activity is ignored
        mode_ok_q  <= 1'b1;
        ft_q       <= mode_sy;
        load_sel_q <= ld_sy;
        def_ofs_q  <= def_ofs_d;
      end
    end
  end

  // Software offsets override the reset defaults when enabled
  reg              ovr_q;
  reg [`CNT_W-1:0] emp_ofs_q;
  reg [`CNT_W-1:0] full_ofs_q;
  wire [`CNT_W-1:0] n_ofs = ovr_q ? emp_ofs_q  : def_ofs_q;
  wire [`CNT_W-1:0] m_ofs = ovr_q ? full_ofs_q : def_ofs_q;

  // Storage and pointers
  reg [`DATA_W-1:0] mem [0:`DEPTH-1];
  reg [`ADDR_W-1:0] wptr_q, rptr_q;
  reg [`CNT_W-1:0]  mem_cnt_q;
  reg               valid_q;
  reg [1:0]         fall_cnt_q;

  wire mem_ne  = (mem_cnt_q != {`CNT_W{1'b0}});
  wire mem_ful = (mem_cnt_q == `DEPTH);
  // Writes gate on the true count, not the lagging pin flag
  wire wr_go   = mode_ok_q & wclk_rise & ~wen_sy & ~mem_ful;
  wire rd_std  = mode_ok_q & ~ft_q & rclk_rise & ~ren_sy
                 & mem_ne;
  wire rd_ft   = mode_ok_q & ft_q & rclk_rise & ~ren_sy & valid_q;
  wire fall_go = mode_ok_q & ft_q & rclk_rise & ~valid_q & mem_ne
                 & (fall_cnt_q == `FALL_LAST);
  wire pop     = rd_std | fall_go | (rd_ft & mem_ne);

  always @(posedge pclk) begin
    if (wr_go)
      mem[wptr_q] <= din_s2;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= {`ADDR_W{1'b0}};
      rptr_q <= {`ADDR_W{1'b0}};
    end else begin
      if (wr_go)
        wptr_q <= wptr_q + {{(`ADDR_W-1){1'b0}}, 1'b1};
      if (pop)
        rptr_q <= rptr_q + {{(`ADDR_W-1){1'b0}}, 1'b1};
    end
  end

  // The output word is a register of its own, so dout only moves on a pop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dout <= {`DATA_W{1'b0}};
    else if (pop)
      dout <= mem[rptr_q];
  end

  // A write and a pop in one cycle leave the count as it was
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_cnt_q <= {`CNT_W{1'b0}};
    end else begin
      case ({wr_go, pop})
        2'b10:   mem_cnt_q <= mem_cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
        2'b01:   mem_cnt_q <= mem_cnt_q - {{(`CNT_W-1){1'b0}}, 1'b1};
        default: mem_cnt_q <= mem_cnt_q;
      endcase
    end
  end

  // Output register: loaded by fall-through, emptied by last read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q    <= 1'b0;
      fall_cnt_q <= 2'h0;
    end else begin
      if (fall_go)
        valid_q <= 1'b1;
      else if (rd_ft & ~mem_ne)
        valid_q <= 1'b0;
      if (~ft_q | valid_q | ~mem_ne)
        fall_cnt_q <= 2'h0;
      else if (rclk_rise & ~fall_go)
        fall_cnt_q <= fall_cnt_q + 2'h1;
    end
  end

  // Word count as seen at the pins; fall-through adds the output word
  wire [`CNT_W-1:0] total = mem_cnt_q
                            + {{(`CNT_W-1){1'b0}}, ft_q & valid_q};
  wire [`CNT_W-1:0] ae_lim = n_ofs + {{(`CNT_W-1){1'b0}}, ft_q};
  wire [`CNT_W-1:0] hf_lim = ft_q ? `HF_FT : `HF_STD;
  wire [`CNT_W-1:0] af_lim = (ft_q ? `AF_BASE_FT : `AF_BASE_STD) - m_ofs;
  wire ae_raw_n = (total > ae_lim);
  wire hf_raw_n = (total < hf_lim);
  wire af_raw_n = (total < af_lim);
  wire full_raw = ft_q ? (total == `DEPTH_FT) : mem_ful;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      almost_empty_flag_n <= 1'b0;
      half_full_flag_n    <= 1'b1;
      almost_full_flag_n  <= 1'b1;
    end else if (mode_ok_q) begin
      almost_empty_flag_n <= ae_raw_n;
      half_full_flag_n    <= hf_raw_n;
      almost_full_flag_n  <= af_raw_n;
    end
  end

  // Full / input-ready: two stages on write clock edges
  reg wf1_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wf1_q         <= 1'b0;
      full_flag_n   <= 1'b1;
      input_ready_n <= 1'b1;
    end else if (strap_take) begin
      wf1_q         <= 1'b0;
      full_flag_n   <= 1'b1;
      input_ready_n <= ~mode_sy;
    end else if (mode_ok_q & wclk_rise) begin
      wf1_q         <= full_raw;
      full_flag_n   <= ft_q ? 1'b1 : ~wf1_q;
      input_ready_n <= ft_q ? wf1_q : 1'b1;
    end
  end

  // Empty: two stages; output-ready: three stages, on read clock edges.
  // The stages only delay the pins; reads are gated by the true count.
  wire rd_raw = ft_q ? ~(valid_q | mem_ne) : mem_ne;
  reg  re1_q, re2_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      re1_q <= 1'b0;
      re2_q <= 1'b0;
    end else if (strap_take) begin
      re1_q <= mode_sy;
      re2_q <= mode_sy;
    end else if (mode_ok_q & rclk_rise) begin
      re1_q <= rd_raw;
      re2_q <= re1_q;
    end
  end

  // Fall-through has no empty flag, so it must idle high from the strap
  // edge on, not only after the first read clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      empty_flag_n <= 1'b0;
    else if (strap_take)
      empty_flag_n <= mode_sy;
    else if (mode_ok_q & rclk_rise)
      empty_flag_n <= ft_q ? 1'b1 : re1_q;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      output_ready_n <= 1'b1;
    else if (strap_take)
      output_ready_n <= 1'b1;
    else if (mode_ok_q & rclk_rise)
      output_ready_n <= ft_q ? re2_q : 1'b1;
  end

  // APB slave, one wait state so that read data leaves a flop
  wire acc    = psel & penable & ~pready;
  wire wr_acc = psel & penable & pready & pwrite;
  reg  [31:0] rd_d;
  reg         err_d;

  always @* begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (paddr)
      `REG_CTRL:      rd_d = {31'h00000000, ovr_q};
      `REG_EMPTY_OFS: rd_d = {15'h0000, n_ofs};
      `REG_FULL_OFS:  rd_d = {15'h0000, m_ofs};
      `REG_STATUS:    rd_d = {22'h000000, mode_ok_q, load_sel_q, ft_q,
                              almost_full_flag_n, half_full_flag_n,
                              almost_empty_flag_n, input_ready_n,
                              output_ready_n, full_flag_n, empty_flag_n};
      `REG_COUNT:     rd_d = {15'h0000, total};
      default:        err_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc & err_d;
      prdata  <= (acc & ~pwrite) ? rd_d : 32'h00000000;
    end
  end

  // Writes land at the edge where pready is seen high; unmapped
  // addresses leave every register alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_q      <= 1'b0;
      emp_ofs_q  <= {`CNT_W{1'b0}};
      full_ofs_q <= {`CNT_W{1'b0}};
    end else if (wr_acc) begin
      case (paddr)
        `REG_CTRL:      ovr_q      <= pwdata[`CTRL_OVR_BIT];
        `REG_EMPTY_OFS: emp_ofs_q  <= pwdata[`CNT_W-1:0];
        `REG_FULL_OFS:  full_ofs_q <= pwdata[`CNT_W-1:0];
        default:        ovr_q      <= ovr_q;
      endcase
    end
  end

endmodule // fifo_flags

//--- shared/fifo_flags_consts.vh
// Constants for the dual-clock FIFO flag block: depth, thresholds,
// default offsets and register map. Included by the design, checker and testbench files.
`ifndef FIFO_FLAGS_CONSTS_VH
`define FIFO_FLAGS_CONSTS_VH

`define DATA_W        36
`define CNT_W         17
`define ADDR_W        16
`define DEPTH         17'h10000
`define DEPTH_FT      17'h10001
`define HF_STD        17'h08001
`define HF_FT         17'h08002
`define AF_BASE_STD   17'h10000
`define AF_BASE_FT    17'h10001
`define FALL_LAST     2'h2
`define STRAP_AT      2'h2

// Default offsets picked at master reset: {load_select, hi, lo}
`define OFS_L_HL      17'h03FFF
`define OFS_L_LH      17'h01FFF
`define OFS_L_HH      17'h00FFF
`define OFS_L_LL      17'h0007F
`define OFS_H_HL      17'h007FF
`define OFS_H_LL      17'h003FF
`define OFS_H_LH      17'h001FF
`define OFS_H_HH      17'h000FF

// APB register byte addresses
`define REG_CTRL      8'h00
`define REG_EMPTY_OFS 8'h04
`define REG_FULL_OFS  8'h08
`define REG_STATUS    8'h0C
`define REG_COUNT     8'h10

// CTRL fields
`define CTRL_OVR_BIT  0
// STATUS fields
`define ST_EMPTY      0
`define ST_FULL       1
`define ST_OUTRDY     2
`define ST_INRDY      3
`define ST_AE         4
`define ST_HF         5
`define ST_AF         6
`define ST_FT         7
`define ST_LOADSEL    8
`define ST_READY      9

`endif

//--- verif/fifo_flags_properties.sv
// Checker for the FIFO flag block: APB handshake and flag timing.
// Bound to fifo_flags; sees its ports only.
`timescale 1ns/1ps
`include "fifo_flags_consts.vh"
module fifo_flags_chk (
  input wire               pclk,
  input wire               presetn,
  input wire [7:0]         paddr,
  input wire               psel,
  input wire               penable,
  input wire [31:0]        prdata,
  input wire               pready,
  input wire               pslverr,
  input wire               rclk_pin,
  input wire               timing_mode_serial_in,
  input wire [`DATA_W-1:0] dout,
  input wire               empty_flag_n,
  input wire               full_flag_n,
  input wire               output_ready_n,
  input wire               input_ready_n
);
  reg  [2:0] up_q;
  reg        mode_q;
  reg  [1:0] rs_q;
  reg  [3:0] rgap_q;
  wire       live = (up_q == 3'h7);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode is copied at the same edge the block takes its straps
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q   <= 3'h0;
      mode_q <= 1'b0;
      rs_q   <= 2'h0;
      rgap_q <= 4'hF;
    end else begin
      if (up_q != 3'h7)
        up_q <= up_q + 3'h1;
      if (up_q == 3'h2)
        mode_q <= timing_mode_serial_in;
      rs_q   <= {rs_q[0], rclk_pin};
      rgap_q <= (rs_q == 2'h1) ? 4'h0 :
                rgap_q + {3'h0, rgap_q != 4'hF};
    end
  end
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  slverr_addr_a: assert property
    (pslverr |-> (paddr > 8'h10 || paddr[1:0] != 2'h0))
    else $error("pslverr on mapped address");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  std_flags_a: assert property
    (live && !mode_q |-> output_ready_n && input_ready_n)
    else $error("ready flags active in standard mode");
  ft_flags_a: assert property
    (live && mode_q |-> empty_flag_n && full_flag_n)
    else $error("empty or full active in fall-through");
  dout_rclk_a: assert property
    (live && $changed(dout) |-> rgap_q < 4'h8)
    else $error("dout moved away from a read clock edge");
  empty_rclk_a: assert property
    (live && !mode_q && $changed(empty_flag_n) |-> rgap_q < 4'h8)
    else $error("empty flag moved away from a read clock edge");
  ready_rclk_a: assert property
    (live && mode_q && $changed(output_ready_n) |-> rgap_q < 4'h8)
    else $error("output ready moved away from a read clock edge");
endmodule // fifo_flags_chk

bind fifo_flags fifo_flags_chk u_chk (.*);

//--- verif/fifo_peer.sv
// Writer and reader beside the FIFO: clock pins, enables and data.
// Called at a pclk rising edge; clock pins stand still between frames.
`timescale 1ns/1ps
module fifo_peer (
  input  wire        pclk,
  output reg         wclk_pin = 1'b0,
  output reg         wen_n = 1'b1,
  output reg  [35:0] din = 36'h0,
  output reg         rclk_pin = 1'b0,
  output reg         ren_n = 1'b1
);
  // One 200 ns clock period per frame: enables and data lead the rise by
  // 75 ns and hold 100 ns past it
  task frame(input w, input r, input [35:0] d);
    begin
      wen_n <= !w;
      ren_n <= !r;
      din <= d;
      repeat (3) @(posedge pclk);
      wclk_pin <= 1'b1;
      rclk_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      wclk_pin <= 1'b0;
      rclk_pin <= 1'b0;
      wen_n <= 1'b1;
      ren_n <= 1'b1;
      din <= ~d;
      @(posedge pclk);
    end
  endtask
endmodule // fifo_peer

//--- verif/testbench.sv
// Self-checking bench for fifo_flags: APB master, queue model, peer.
// Assumes the peer's frames are the only write and read traffic.
`timescale 1ns/1ps
`include "fifo_flags_consts.vh"
module testbench;
  localparam N_OFS = 1;
  localparam M_OFS = 65532;
  localparam [135:0] DFLT = {17'h000FF, 17'h007FF, 17'h001FF,
    17'h003FF, 17'h00FFF, 17'h03FFF, 17'h01FFF, 17'h0007F};
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  reg         timing_mode_serial_in = 1'b0;
  reg         load_select = 1'b0;
  reg         default_offset_pick_hi = 1'b0;
  reg         default_offset_pick_lo = 1'b0;
  wire [31:0] prdata;
  wire [35:0] din, dout;
  wire        pready, pslverr, wclk_pin, wen_n, rclk_pin, ren_n;
  wire        empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
  wire        almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
  wire [6:0]  flags_seen = {almost_full_flag_n, half_full_flag_n,
    almost_empty_flag_n, input_ready_n, output_ready_n, full_flag_n,
    empty_flag_n};
  reg  [31:0] seed = 32'hA0B1;
  reg  [35:0] q[$];
  reg  [35:0] last = 36'h0;
  reg         ft = 1'b0;
  integer     num_errors = 0;
  integer     num_checks = 0;
  integer     k;
  fifo_flags u_dut (.*);
  fifo_peer u_peer (.*);
  always #12.5 pclk = ~pclk;
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [6:0] fexp(input integer n);
    if (ft)
      fexp = {n < 65537 - M_OFS, 1'b1, n > N_OFS + 1, 1'b0, n == 0, 2'h3};
    else
      fexp = {n < 65536 - M_OFS, 1'b1, n > N_OFS, 3'h7, n != 0};
  endfunction
  task stop_test;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task check(input string what, input [35:0] exp, input [35:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value %s exp %h got %h", what, exp, got);
      end
    end
  endtask
  // Read data is compared only on reads; a hung slave ends the run
  task apb(input w, input [7:0] a, input [31:0] d, input e);
    integer i;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
        @(posedge pclk);
        i = i + 1;
      end while (pready !== 1'b1 && i < 40);
      if (i == 40) begin
        num_errors = num_errors + 1;
        stop_test;
      end
      if (!w) check("prdata", {4'h0, d}, {4'h0, prdata});
      check("pslverr", {35'h0, e}, {35'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rst(input m, input [2:0] s);
    begin
      presetn <= 1'b0;
      timing_mode_serial_in <= m;
      {load_select, default_offset_pick_hi, default_offset_pick_lo} <= s;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      timing_mode_serial_in <= ~m;
      load_select <= ~s[2];
      ft = m;
      q.delete();
      last = 36'h0;
    end
  endtask
  // Three idle frames let the lagging pin flags catch up
  task step(input w, input r);
    reg [35:0] d;
    integer    n;
    begin
      d = {seed[3:0], seed};
      seed = lfsr(seed);
      u_peer.frame(w, r, d);
      if (w) q.push_back(d);
      if (r && q.size() > 0) last = q.pop_front();
      repeat (3) u_peer.frame(1'b0, 1'b0, 36'h0);
      n = q.size();
      check("flags", {29'h0, fexp(n)}, {29'h0, flags_seen});
      if (!ft) check("dout", last, dout);
      else if (n > 0) check("dout", q[0], dout);
      apb(1'b0, `REG_COUNT, n[31:0], 1'b0);
    end
  endtask
  task run(input m);
    begin
      rst(m, 3'h2);
      apb(1'b0, `REG_STATUS, {22'h0, 2'h2, m, fexp(0)}, 1'b0);
      apb(1'b0, 8'h20, 32'h0, 1'b1);
      apb(1'b1, `REG_EMPTY_OFS, N_OFS, 1'b0);
      apb(1'b1, `REG_FULL_OFS, M_OFS, 1'b0);
      apb(1'b1, `REG_CTRL, 32'h1, 1'b0);
      apb(1'b0, `REG_FULL_OFS, M_OFS, 1'b0);
      step(1'b0, 1'b0);
      repeat (6) step(1'b1, 1'b0);
      repeat (7) step(1'b0, 1'b1);
      $display("mode %0d test done", m);
    end
  endtask
  initial begin
    for (k = 0; k < 8; k = k + 1) begin
      rst(1'b0, k[2:0]);
      apb(1'b0, `REG_FULL_OFS, {15'h0, DFLT[k*17 +: 17]}, 1'b0);
    end
    $display("default offset test done");
    run(1'b0);
    run(1'b1);
    stop_test;
  end
endmodule // testbench
